// ===== ppm_defines.svh
// constants for the parallel-port floppy pin mux: register map, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH
`define ADDR_CHIP_CFG5      4'h0
`define ADDR_DIG_OUT        4'h1
`define ADDR_CFG_CTRL       4'h2
`define ADDR_DSR            4'h3
`define ADDR_MUX_CTRL       4'h4
`define ADDR_STATUS         4'h5
`define CFG5_ROUTE_LO       5
`define CFG5_ROUTE_HI       6
`define CFG5_DISABLE_BIT    7
`define ROUTE_SEL_LOW       2'h1
`define ROUTE_SEL_HIGH      2'h2
`define MUX_EN_BIT          0
`define MUX_FOURDRV_BIT     1
`define MUX_HEAD_BIT        2
`define MUX_DIR_BIT         3
`define MUX_IR_OUT_BIT      4
`define RST_CHIP_CFG5       8'h00
`define RST_DIG_OUT         8'h00
`define RST_RATE            2'h0
`define RST_MUX_CTRL        8'h00
`endif

// ===== ppm_pkg.sv
// types for the parallel-port floppy pin mux
// assumes the defines header is compiled alongside
package pin_mux_pkg;
  typedef enum logic [1:0] {
    ROUTE_PRINTER = 2'b00,
    ROUTE_FLOPPY  = 2'b01
  } route_mode_t;
endpackage : pin_mux_pkg

// ===== drive_sel_if.sv
// interface carrying drive-select decode between the mux and its decoder
// assumes a single clock domain; purely combinational signals
`timescale 1ns/10ps
interface drive_sel_if;
  logic [1:0] drv_sel;
  logic       four_drive;
  logic       motor_0_n;
  logic       drv_sel_0_n;
  logic       drv_sel_1_n;
  modport ctrl (output drv_sel, output four_drive, output motor_0_n, input drv_sel_0_n, input drv_sel_1_n);
  modport dec  (input drv_sel, input four_drive, input motor_0_n, output drv_sel_0_n, output drv_sel_1_n);
endinterface : drive_sel_if

// ===== drive_sel_decode.sv
// drive-select line encoder: decoded lines in 2-drive mode, encoded in 4-drive mode
// assumes inputs come from registers on the same clock
`timescale 1ns/10ps
module drive_sel_decode (
  drive_sel_if.dec ds
);
  // 2-drive: one active-low line per drive; 4-drive: select bits passed, qualified by motor 0
  wire dec0_n = ~(ds.drv_sel == 2'h0);
  wire dec1_n = ~(ds.drv_sel == 2'h1);
  wire enc0_n = ~ds.drv_sel[0] | ds.motor_0_n;
  wire enc1_n = ~ds.drv_sel[1] | ds.motor_0_n;
  assign ds.drv_sel_0_n = ds.four_drive ? enc0_n : dec0_n; // [R8]
  assign ds.drv_sel_1_n = ds.four_drive ? enc1_n : dec1_n; // [R8]
endmodule : drive_sel_decode

// ===== parallel_port_floppy_pin_mux.sv
// parallel-port pins shared with floppy controller signals, plus infrared select pin direction
// assumes pins are synchronised here; parallel-port and floppy core signals are on sys_clk_in
`timescale 1ns/10ps
`include "ppm_defines.svh"

// What this block does
// R1 - select low and routing 01 puts floppy signals on parallel pins
// R2 - select high and routing 10 also puts floppy signals on parallel pins
// R3 - any other combination keeps normal parallel-port function
// R4 - data pins 0-5 and 7 become floppy inputs in floppy routing
// R5 - floppy outputs mapped onto data pin 6 and control pins
// R6 - rate bit 1 follows bit 1 of last written rate register, on density select always and on autofeed in floppy routing
// R7 - rate bit 0 follows bit 0 of last written rate register
// R8 - drive selects from output register bits 1:0, decoded or encoded
// R9 - motor enables active low from output register bits 5:4
// R10 - head select low for side 1, high for side 0
// R11 - direction active to step in, inactive to step out
// R12 - infrared select pins inputs after reset, pins 0-2 outputs when serial port enables
// R13 - each shared pin carries exactly one function at a time
// R14 - floppy routing only when mux enabled and config five bit 7 clear
// R15 - board drives printer-versus-floppy select to name connected device
module parallel_port_floppy_pin_mux (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // board select pin
  input  wire logic       printer_floppy_select_in,
  // parallel data pins
  input  wire logic [7:0] par_data_in,
  output logic      [7:0] par_data_out,
  output logic      [7:0] par_data_oe_out,
  // parallel control pins
  output logic            select_in_addr_strobe_out,
  output logic            autofeed_data_strobe_out,
  output logic            init_out,
  input  wire logic       ack_in,
  input  wire logic       error_in,
  input  wire logic       printer_selected_in,
  input  wire logic       paper_out_in,
  input  wire logic       busy_in,
  output logic      [4:0] ctrl_pin_oe_out,
  output logic      [4:0] ctrl_pin_val_out,
  // parallel port core side
  input  wire logic [7:0] pp_data_in,
  input  wire logic       pp_data_oe_in,
  input  wire logic       pp_slin_in,
  input  wire logic       pp_afd_in,
  input  wire logic       pp_init_in,
  output logic      [7:0] pp_data_out,
  output logic      [4:0] pp_status_out,
  // floppy core side
  input  wire logic       fdc_step_in,
  input  wire logic       fdc_write_gate_in,
  input  wire logic       fdc_write_data_in,
  output logic      [6:0] fdc_sense_out,
  output logic            motor_on_0_n_out,
  output logic            motor_on_1_n_out,
  output logic            drive_sel_0_n_out,
  output logic            head_side_select_n_out,
  output logic            head_dir_out,
  output logic            density_select_out,
  output logic            rate_bit_0_out,
  // infrared select pins
  input  wire logic [3:0] infrared_select_pins_in,
  output logic      [3:0] infrared_select_pins_out,
  output logic      [3:0] infrared_select_pins_oe_out,
  output logic      [3:0] infrared_id_out
);
  logic [7:0] chip_config_five_r;
  logic [7:0] digital_output_reg_r;
  logic [7:0] mux_ctrl_r;
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic [7:0] rdata_nxt;
  // pin synchronisers: stage one feeds stage two only
  logic [7:0] pd_s1_r, pd_s2_r;
  logic [4:0] st_s1_r, st_s2_r;
  logic [3:0] ir_s1_r, ir_s2_r;
  logic       sel_s1_r, sel_s2_r;
  pin_mux_pkg::route_mode_t route_mode;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_s1_r  <= 8'h00;
      pd_s2_r  <= 8'h00;
      st_s1_r  <= 5'h00;
      st_s2_r  <= 5'h00;
      ir_s1_r  <= 4'h0;
      ir_s2_r  <= 4'h0;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      pd_s1_r  <= par_data_in;
      pd_s2_r  <= pd_s1_r;
      st_s1_r  <= {busy_in, paper_out_in, printer_selected_in, error_in, ack_in};
      st_s2_r  <= st_s1_r;
      ir_s1_r  <= infrared_select_pins_in;
      ir_s2_r  <= ir_s1_r;
      sel_s1_r <= printer_floppy_select_in; // [R15]
      sel_s2_r <= sel_s1_r;
    end
  end

  // register decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a, input logic stb);
    hit = stb && (a == ref_a);
  endfunction : hit

  wire wr_cfg5 = hit(reg_addr_in, `ADDR_CHIP_CFG5, reg_wr_in);
  wire wr_dig_out  = hit(reg_addr_in, `ADDR_DIG_OUT, reg_wr_in);
  wire wr_cfg_ctrl = hit(reg_addr_in, `ADDR_CFG_CTRL, reg_wr_in);
  wire wr_dsr  = hit(reg_addr_in, `ADDR_DSR, reg_wr_in);
  wire wr_mux  = hit(reg_addr_in, `ADDR_MUX_CTRL, reg_wr_in);

  // last written of the two rate registers wins
  assign rate_nxt = (wr_cfg_ctrl || wr_dsr) ? reg_wdata_in[1:0] : rate_r; // [R6] [R7]

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      chip_config_five_r   <= `RST_CHIP_CFG5;
      digital_output_reg_r <= `RST_DIG_OUT;
      mux_ctrl_r           <= `RST_MUX_CTRL;
      rate_r               <= `RST_RATE;
      reg_rdata_out        <= 8'h00;
    end else begin
      if (wr_cfg5) chip_config_five_r <= reg_wdata_in;
      if (wr_dig_out) digital_output_reg_r <= reg_wdata_in;
      if (wr_mux) mux_ctrl_r <= reg_wdata_in;
      rate_r        <= rate_nxt;
      reg_rdata_out <= rdata_nxt;
    end
  end

  wire [1:0] route_field = chip_config_five_r[`CFG5_ROUTE_HI:`CFG5_ROUTE_LO];
  wire mux_enabled  = mux_ctrl_r[`MUX_EN_BIT] && !chip_config_five_r[`CFG5_DISABLE_BIT]; // [R14]
  wire route_sel_lo = !sel_s2_r && (route_field == `ROUTE_SEL_LOW);  // [R1]
  wire route_sel_hi = sel_s2_r && (route_field == `ROUTE_SEL_HIGH);  // [R2]
  wire floppy_on    = mux_enabled && (route_sel_lo || route_sel_hi); // [R3]
  assign route_mode = floppy_on ? pin_mux_pkg::ROUTE_FLOPPY : pin_mux_pkg::ROUTE_PRINTER; // [R13]
  wire fl = (route_mode == pin_mux_pkg::ROUTE_FLOPPY);

  // readback: unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_CHIP_CFG5: rdata_nxt = chip_config_five_r;
        `ADDR_DIG_OUT:   rdata_nxt = digital_output_reg_r;
        `ADDR_CFG_CTRL,
        `ADDR_DSR:       rdata_nxt = {6'h00, rate_r};
        `ADDR_MUX_CTRL:  rdata_nxt = mux_ctrl_r;
        `ADDR_STATUS:    rdata_nxt = {2'h0, ir_s2_r, sel_s2_r, fl};
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  // drive select and motor lines
  drive_sel_if ds_if ();
  assign ds_if.drv_sel    = digital_output_reg_r[1:0];
  assign ds_if.four_drive = mux_ctrl_r[`MUX_FOURDRV_BIT];
  assign ds_if.motor_0_n  = ~digital_output_reg_r[4];
  drive_sel_decode u_dsel (
    .ds (ds_if.dec)
  );
  wire motor0_n = ~digital_output_reg_r[4]; // [R9]
  wire motor1_n = ~digital_output_reg_r[5]; // [R9]
  wire head_n   = ~mux_ctrl_r[`MUX_HEAD_BIT]; // [R10]
  wire dir_act  = mux_ctrl_r[`MUX_DIR_BIT];   // [R11]
  assign motor_on_0_n_out       = motor0_n;
  assign motor_on_1_n_out       = motor1_n;
  assign drive_sel_0_n_out      = ds_if.drv_sel_0_n;
  assign head_side_select_n_out = head_n;
  assign head_dir_out           = dir_act;
  assign density_select_out     = rate_r[1];
  assign rate_bit_0_out         = rate_r[0]; // [R7]

  // data pins: floppy mode drives only pin 6, the rest are inputs
  assign par_data_out    = fl ? {1'b0, rate_r[0], 6'h00} : pp_data_in;              // [R5]
  assign par_data_oe_out = fl ? 8'h40 : {8{pp_data_oe_in}};                        // [R4]
  assign fdc_sense_out   = fl ? {pd_s2_r[7], pd_s2_r[5:0]} : 7'h00;                // [R4]
  assign pp_data_out     = fl ? 8'h00 : pd_s2_r;                                   // [R13]
  assign pp_status_out   = fl ? 5'h00 : st_s2_r;                                   // [R13]

  // control pins; ack/error/select/paper/busy become floppy outputs
  assign select_in_addr_strobe_out = fl ? fdc_step_in : pp_slin_in; // [R5]
  assign autofeed_data_strobe_out  = fl ? rate_r[1] : pp_afd_in;    // [R5] [R6]
  assign init_out                  = fl ? dir_act : pp_init_in;     // [R5] [R11]
  assign ctrl_pin_oe_out           = fl ? 5'h1F : 5'h00;
  assign ctrl_pin_val_out          = fl ? {motor1_n, fdc_write_data_in, fdc_write_gate_in, head_n,
                                           ds_if.drv_sel_1_n} : 5'h00; // [R5]

  // infrared select pins: inputs until serial port 2 asks for output on pins 0-2; pin 3 stays input
  wire ir_out_en = mux_ctrl_r[`MUX_IR_OUT_BIT];
  assign infrared_select_pins_oe_out = ir_out_en ? 4'h7 : 4'h0; // [R12]
  assign infrared_select_pins_out    = 4'h0;
  assign infrared_id_out             = ir_s2_r;

  // named steps shared by the checks below
  sequence s_rate_write;
    wr_cfg_ctrl || wr_dsr;
  endsequence
  sequence s_floppy_route;
    fl;
  endsequence
  sequence s_printer_route;
    !fl;
  endsequence
  sequence s_out_reg_write;
    wr_dig_out;
  endsequence

  a_route_needs_en: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R14]
    fl |-> (mux_ctrl_r[`MUX_EN_BIT] && !chip_config_five_r[`CFG5_DISABLE_BIT]))
    else $error("floppy routing without mux enable");
  a_route_lo_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1]
    (mux_enabled && !sel_s2_r && route_field == `ROUTE_SEL_LOW) |-> fl)
    else $error("routing 01 with select low not taken");
  a_route_hi_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R2]
    (mux_enabled && sel_s2_r && route_field == `ROUTE_SEL_HIGH) |-> fl)
    else $error("routing 10 with select high not taken");
  a_route_other: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R3]
    (route_field == 2'h0 || route_field == 2'h3) |-> !fl && par_data_out == pp_data_in)
    else $error("printer function lost");
  a_data_inputs: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
    s_floppy_route |-> par_data_oe_out == 8'h40)
    else $error("floppy input pin driven");
  a_rate_latest: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6]
    s_rate_write |=> rate_bit_0_out == $past(reg_wdata_in[0]) && density_select_out == $past(reg_wdata_in[1]))
    else $error("rate bits not from latest write");
  a_rate_pin6: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R7]
    s_floppy_route |-> par_data_out[6] == rate_bit_0_out)
    else $error("rate bit 0 not on data pin 6");
  a_motor_low: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R9]
    s_out_reg_write |=> motor_on_1_n_out == !$past(reg_wdata_in[5]))
    else $error("motor 1 not active low");
  a_drive_two: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
    (!ds_if.four_drive && digital_output_reg_r[1:0] == 2'h0) |-> !drive_sel_0_n_out && ds_if.drv_sel_1_n)
    else $error("2-drive decode wrong");
  a_ir_reset_in: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R12]
    !ir_out_en |-> infrared_select_pins_oe_out == 4'h0)
    else $error("infrared select driven in input mode");
  a_head_side: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R10]
    s_floppy_route |-> ctrl_pin_val_out[1] == !mux_ctrl_r[`MUX_HEAD_BIT])
    else $error("head select level wrong");
  a_rate_bit_one: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6]
    s_rate_write |=> !fl || autofeed_data_strobe_out == $past(reg_wdata_in[1]))
    else $error("rate bit 1 pin not from latest write");
  a_rate_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R7]
    (!wr_cfg_ctrl && !wr_dsr) |=> $stable(rate_r))
    else $error("rate bits moved without a write");
  a_printer_strobes: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R3]
    s_printer_route |-> select_in_addr_strobe_out == pp_slin_in && autofeed_data_strobe_out == pp_afd_in
                        && init_out == pp_init_in)
    else $error("printer strobes not passed through");
  a_printer_pins_free: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
    s_printer_route |-> ctrl_pin_oe_out == 5'h00 && fdc_sense_out == 7'h00)
    else $error("floppy function on printer pins");
  a_floppy_pins: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
    s_floppy_route |-> pp_data_out == 8'h00 && pp_status_out == 5'h00)
    else $error("printer function on floppy pins");
  a_ctrl_map: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R5]
    s_floppy_route |-> select_in_addr_strobe_out == fdc_step_in
                       && ctrl_pin_val_out[3:2] == {fdc_write_data_in, fdc_write_gate_in})
    else $error("floppy output pin map wrong");
  a_sense_map: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
    s_floppy_route |-> fdc_sense_out[6] == pd_s2_r[7] && fdc_sense_out[5:0] == pd_s2_r[5:0])
    else $error("floppy input pin map wrong");
  a_dir_pin: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R11]
    s_floppy_route |-> init_out == mux_ctrl_r[`MUX_DIR_BIT] && head_dir_out == mux_ctrl_r[`MUX_DIR_BIT])
    else $error("direction level wrong");
  a_motor_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R9]
    s_out_reg_write |=> motor_on_0_n_out == !$past(reg_wdata_in[4]))
    else $error("motor 0 not active low");
  a_drive_four: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
    (ds_if.four_drive && !digital_output_reg_r[4]) |-> drive_sel_0_n_out && ds_if.drv_sel_1_n)
    else $error("4-drive select without motor 0");
  a_drive_enc: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
    (ds_if.four_drive && digital_output_reg_r[4]) |-> drive_sel_0_n_out == !digital_output_reg_r[0]
                                                      && ds_if.drv_sel_1_n == !digital_output_reg_r[1])
    else $error("4-drive encode wrong");
  a_ir_pin3: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R12]
    !infrared_select_pins_oe_out[3])
    else $error("infrared select pin 3 driven");
  a_ir_drive: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R12]
    ir_out_en |-> infrared_select_pins_oe_out == 4'h7 && infrared_select_pins_out == 4'h0)
    else $error("infrared select output mode wrong");
  a_data_fixed: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
    s_floppy_route |-> par_data_out[7] == 1'b0 && par_data_out[5:0] == 6'h00)
    else $error("floppy input pin carries data");
  a_disable_bit: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R14]
    chip_config_five_r[`CFG5_DISABLE_BIT] |-> !fl)
    else $error("floppy routing with disable bit set");
  a_enable_off: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R14]
    !mux_ctrl_r[`MUX_EN_BIT] |-> !fl)
    else $error("floppy routing with mux off");
  a_read_cfg: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
    (reg_rd_in && reg_addr_in == `ADDR_CHIP_CFG5) |=> reg_rdata_out == $past(chip_config_five_r))
    else $error("config five readback wrong");
  a_read_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
endmodule : parallel_port_floppy_pin_mux

// ===== floppy_drive_model.sv
// external drive or printer on the shared parallel pins
// assumes device enables are high while the device drives a pin
`timescale 1ns/10ps
module floppy_drive_model (
  // control
  input  wire logic       clk_in,
  input  wire logic       sel_level_in,
  input  wire logic [7:0] far_data_in,
  input  wire logic [4:0] far_stat_in,
  // device side
  input  wire logic [7:0] dev_oe_in,
  input  wire logic [7:0] dev_val_in,
  input  wire logic [4:0] ctl_oe_in,
  input  wire logic [4:0] ctl_val_in,
  // resolved wires
  output logic      [7:0] data_wire_out,
  output logic      [4:0] stat_wire_out,
  output logic            sel_out
);
  logic [7:0] flip_r = 8'h55;
  // released line 6 toggles so a stale level never passes
  always @(posedge clk_in) flip_r <= ~flip_r;
  assign sel_out = sel_level_in;
  assign data_wire_out = (dev_oe_in & dev_val_in) |
                         (~dev_oe_in & {far_data_in[7], flip_r[6], far_data_in[5:0]});
  assign stat_wire_out = (ctl_oe_in & ctl_val_in) | (~ctl_oe_in & far_stat_in);
endmodule : floppy_drive_model

// ===== parallel_port_floppy_pin_mux_tb_top.sv
// self-checking bench for the parallel-port floppy pin mux
// assumes the drive model resolves every shared pin
`timescale 1ns/10ps
module parallel_port_floppy_pin_mux_tb_top;
  logic       sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, sel_lvl = 1'b0;
  logic [3:0] reg_addr_in = 4'h0, infrared_select_pins_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, par_data_in, par_data_out, par_data_oe_out;
  logic [7:0] pp_data_in = 8'hA5, pp_data_out, far_data = 8'h3C;
  logic       printer_floppy_select_in, select_in_addr_strobe_out, autofeed_data_strobe_out, init_out;
  logic       ack_in, error_in, printer_selected_in, paper_out_in, busy_in;
  logic [4:0] ctrl_pin_oe_out, ctrl_pin_val_out, pp_status_out, stat_w, far_stat = 5'h15;
  logic       pp_data_oe_in = 1'b1, pp_slin_in = 1'b1, pp_afd_in = 1'b0, pp_init_in = 1'b1;
  logic       fdc_step_in = 1'b0, fdc_write_gate_in = 1'b0, fdc_write_data_in = 1'b0;
  logic [6:0] fdc_sense_out;
  logic       motor_on_0_n_out, motor_on_1_n_out, drive_sel_0_n_out, head_side_select_n_out;
  logic       head_dir_out, density_select_out, rate_bit_0_out;
  logic [3:0] infrared_select_pins_out, infrared_select_pins_oe_out, infrared_id_out;
  int         bad_count = 0, compares = 0, cyc = 0;

  assign {busy_in, paper_out_in, printer_selected_in, error_in, ack_in} = stat_w;
  always #2.5 sys_clk_in = ~sys_clk_in;
  parallel_port_floppy_pin_mux dut (.*);
  floppy_drive_model far (.clk_in(sys_clk_in), .sel_level_in(sel_lvl), .far_data_in(far_data),
    .far_stat_in(far_stat), .dev_oe_in(par_data_oe_out), .dev_val_in(par_data_out),
    .ctl_oe_in(ctrl_pin_oe_out), .ctl_val_in(ctrl_pin_val_out), .data_wire_out(par_data_in),
    .stat_wire_out(stat_w), .sel_out(printer_floppy_select_in));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_out);
  endtask : rd
  // pin inputs pass a two-stage synchroniser
  task automatic wait3();
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : wait3
  task automatic t_reset();
    for (int a = 0; a < 6; a++) rd(4'(a), 8'h00, "reset reg");
    chk("motors", 8'h03, {6'h00, motor_on_1_n_out, motor_on_0_n_out});
    chk("ir oe", 8'h00, {4'h0, infrared_select_pins_oe_out});
  endtask : t_reset
  task automatic t_route();
    logic fl;
    for (int k = 0; k < 32; k++) begin
      @(posedge sys_clk_in);
      sel_lvl <= k[2];
      wr(4'h4, {7'h00, ~k[4]});
      wr(4'h0, {k[3], k[1:0], 5'h00});
      wait3();
      fl = ((k[1:0] == 2'b01 && !k[2]) || (k[1:0] == 2'b10 && k[2])) && !k[3] && !k[4];
      chk("ctrl oe", fl ? 8'h1F : 8'h00, {3'h0, ctrl_pin_oe_out});
      chk("data oe", fl ? 8'h40 : 8'hFF, par_data_oe_out);
      chk("data out", fl ? 8'h00 : 8'hA5, par_data_out & par_data_oe_out);
      chk("strobes", fl ? 8'h00 : 8'h05,
          {5'h00, select_in_addr_strobe_out, autofeed_data_strobe_out, init_out});
      chk("pp status", fl ? 8'h00 : 8'h15, {3'h0, pp_status_out});
      chk("pp data", fl ? 8'h00 : 8'hA5, pp_data_out);
      chk("sense", fl ? 8'h3C : 8'h00, {1'b0, fdc_sense_out});
      rd(4'h5, {6'h00, k[2], fl}, "status");
    end
  endtask : t_route
  task automatic t_map();
    @(posedge sys_clk_in);
    sel_lvl <= 1'b0;
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h20);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_in);
      far_data <= i[0] ? 8'hAA : 8'h55;
      fdc_step_in <= i[0];
      fdc_write_gate_in <= ~i[0];
      fdc_write_data_in <= i[0];
      wait3();
      chk("sense", i[0] ? 8'h6A : 8'h15, {1'b0, fdc_sense_out});
      chk("step", {7'h00, i[0]}, {7'h00, select_in_addr_strobe_out});
      chk("ctrl val", i[0] ? 8'h1B : 8'h17, {3'h0, ctrl_pin_val_out});
    end
  endtask : t_map
  task automatic t_rate();
    logic [3:0] ad[3] = '{4'h2, 4'h3, 4'h2};
    logic [7:0] dv[3] = '{8'h01, 8'h02, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      wr(ad[i], dv[i]);
      chk("rate", {6'h00, dv[i][1:0]}, {6'h00, density_select_out, rate_bit_0_out});
      chk("rate pins", {6'h00, dv[i][1:0]}, {6'h00, autofeed_data_strobe_out, par_data_out[6]});
    end
  endtask : t_rate
  task automatic t_dor();
    logic [1:0] ds;
    for (int j = 0; j < 6; j++) begin
      ds = (j < 2) ? 2'(j) : 2'(j - 2);
      wr(4'h4, (j < 2) ? 8'h01 : 8'h03);
      wr(4'h1, {2'b00, j[0], 3'b100, ds});
      chk("motors", {6'h00, ~j[0], 1'b0}, {6'h00, motor_on_1_n_out, motor_on_0_n_out});
      chk("motor pin", {7'h00, ~j[0]}, {7'h00, ctrl_pin_val_out[4]});
      chk("drive sel", {6'h00, (j < 2) ? (ds[0] ? 2'b01 : 2'b10) : ~ds},
          {6'h00, ctrl_pin_val_out[0], drive_sel_0_n_out});
    end
  endtask : t_dor
  task automatic t_head();
    for (int h = 0; h < 4; h++) begin
      wr(4'h4, {4'h0, h[1], h[0], 2'b01});
      chk("head dir", {4'h0, ~h[0], h[1], ~h[0], h[1]},
          {4'h0, head_side_select_n_out, head_dir_out, ctrl_pin_val_out[1], init_out});
    end
  endtask : t_head
  task automatic t_ir();
    wr(4'h4, 8'h11);
    chk("ir oe", 8'h07, {4'h0, infrared_select_pins_oe_out});
    chk("ir out", 8'h00, {4'h0, infrared_select_pins_out});
    @(posedge sys_clk_in);
    infrared_select_pins_in <= 4'h9;
    wait3();
    chk("ir id", 8'h09, {4'h0, infrared_id_out});
    rd(4'h5, 8'h25, "status");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "unmapped");
    rd(4'h4, 8'h11, "mux ctrl");
    wr(4'h4, 8'h01);
    chk("ir oe", 8'h00, {4'h0, infrared_select_pins_oe_out});
  endtask : t_ir
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_route();
    t_map();
    t_rate();
    t_dor();
    t_head();
    t_ir();
    end_sim();
  end
endmodule : parallel_port_floppy_pin_mux_tb_top
